/* File: rtl/ocr_pkg.sv */
// Shared constants, field layouts and types for the over-current configuration bank
package ocr_pkg;

  localparam int         DATA_W        = 9;
  localparam int         WORD_W        = 16;
  localparam int         BANK_BIT      = 13;
  localparam int         ADDR_HI       = 12;
  localparam int         ADDR_LO       = 10;
  localparam logic [2:0] ADDR_OCR      = 3'h4;
  localparam logic [2:0] ADDR_RETRY    = 3'h5;
  localparam logic [8:0] REG_RESET     = 9'h000;
  localparam logic [8:0] READ_UNMAPPED = 9'h000;

  // Over-current configuration fields
  localparam int OCR_HIGH_RANGE = 8;
  localparam int OCR_PRESCALE   = 7;
  localparam int OCR_CLOCK_INT  = 6;
  localparam int OCR_RATIO      = 5;
  localparam int OCR_HIGH_WIN   = 4;
  localparam int OCR_MID_WIN    = 3;
  localparam int OCR_UPPER      = 2;
  localparam int OCR_MIDDLE     = 1;
  localparam int OCR_LOW        = 0;

  // Auto-retry configuration fields
  localparam int RTY_OFFSET  = 8;
  localparam int RTY_PERIOD1 = 3;
  localparam int RTY_PERIOD0 = 2;
  localparam int RTY_UNLIM   = 1;
  localparam int RTY_CTRL    = 0;

  localparam logic [9:0] DIV_LONG      = 10'h200;
  localparam logic [9:0] DIV_SHORT     = 10'h100;
  localparam logic [1:0] THRESH_BULB   = 2'h3;
  localparam logic [1:0] THRESH_MOTOR  = 2'h2;
  localparam int         RETRY_LIMIT   = 16;
  localparam logic       STRAP_BULB    = 1'b0;
  localparam logic       STRAP_MOTOR   = 1'b1;

  typedef enum logic [1:0] {
    LOW_L1 = 2'h0,
    LOW_L2 = 2'h1,
    LOW_L3 = 2'h2
  } low_level_t;

  typedef enum logic [2:0] {
    WIN_NONE       = 3'h0,
    WIN_HIGH1      = 3'h1,
    WIN_HIGH2      = 3'h2,
    WIN_MID1_BULB  = 3'h3,
    WIN_MID2_BULB  = 3'h4,
    WIN_MID1_MOTOR = 3'h5,
    WIN_MID2_MOTOR = 3'h6
  } window_t;

  typedef enum logic [1:0] {
    ST_CAPTURE = 2'b01,
    ST_RUN     = 2'b10
  } phase_t;

  typedef struct packed {
    low_level_t low_level;
    logic       upper_low;
    logic       middle_low;
    logic       middle_used;
    logic [1:0] threshold_count;
    logic       scale_third;
    window_t    first_window;
    window_t    second_window;
    logic [9:0] pwm_divider;
    logic       internal_clock;
    logic       low_ratio;
    logic       offset_add;
    logic [1:0] retry_period;
    logic       retry_enabled;
    logic       retry_unlimited;
  } ch_cfg_t;

  typedef struct packed {
    logic              valid;
    logic [WORD_W-1:0] word;
  } cmd_t;

endpackage : ocr_pkg

/* File: rtl/ocr_field_decode.sv */
// Decoder from raw channel register bits to the channel's settings
`timescale 1ns/1ps
module ocr_field_decode (
  input  wire logic [8:0]       ocr,
  input  wire logic [8:0]       retry,
  input  wire logic             motor,
  output ocr_pkg::ch_cfg_t      cfg
);

  always_comb begin
    cfg = '0;
    if (!ocr[ocr_pkg::OCR_HIGH_RANGE]) begin
      cfg.low_level = ocr_pkg::LOW_L1;
    end else if (ocr[ocr_pkg::OCR_LOW]) begin
      cfg.low_level = ocr_pkg::LOW_L3;
    end else begin
      cfg.low_level = ocr_pkg::LOW_L2;
    end
    cfg.upper_low       = ocr[ocr_pkg::OCR_UPPER];
    // Motor profile has no middle threshold, so its select bit is dropped
    cfg.middle_low      = !motor && ocr[ocr_pkg::OCR_MIDDLE];
    cfg.middle_used     = !motor;
    cfg.threshold_count = motor ? ocr_pkg::THRESH_MOTOR : ocr_pkg::THRESH_BULB;
    cfg.low_ratio       = ocr[ocr_pkg::OCR_RATIO];
    cfg.scale_third     = ocr[ocr_pkg::OCR_RATIO];
    cfg.pwm_divider     = ocr[ocr_pkg::OCR_PRESCALE] ? ocr_pkg::DIV_LONG
                                                     : ocr_pkg::DIV_SHORT;
    cfg.internal_clock  = ocr[ocr_pkg::OCR_CLOCK_INT];
    if (!motor) begin
      cfg.first_window  = ocr[ocr_pkg::OCR_HIGH_WIN] ? ocr_pkg::WIN_HIGH2
                                                     : ocr_pkg::WIN_HIGH1;
      cfg.second_window = ocr[ocr_pkg::OCR_MID_WIN] ? ocr_pkg::WIN_MID2_BULB
                                                    : ocr_pkg::WIN_MID1_BULB;
    end else begin
      cfg.second_window = ocr_pkg::WIN_NONE;
      unique case ({ocr[ocr_pkg::OCR_HIGH_WIN], ocr[ocr_pkg::OCR_MID_WIN]})
        2'b00: cfg.first_window = ocr_pkg::WIN_MID1_MOTOR;
        2'b01: cfg.first_window = ocr_pkg::WIN_MID2_MOTOR;
        2'b10: cfg.first_window = ocr_pkg::WIN_HIGH1;
        2'b11: cfg.first_window = ocr_pkg::WIN_HIGH2;
      endcase
    end
    cfg.offset_add      = retry[ocr_pkg::RTY_OFFSET];
    cfg.retry_period    = {retry[ocr_pkg::RTY_PERIOD1], retry[ocr_pkg::RTY_PERIOD0]};
    // Control bit has opposite sense per load type
    cfg.retry_enabled   = motor ? retry[ocr_pkg::RTY_CTRL] : !retry[ocr_pkg::RTY_CTRL];
    cfg.retry_unlimited = retry[ocr_pkg::RTY_UNLIM];
  end

endmodule : ocr_field_decode

/* File: rtl/retry_limit_counter.sv */
// Per-channel auto-retry counter with limit and sticky count
`timescale 1ns/1ps
module retry_limit_counter #(
  parameter int LIMIT = ocr_pkg::RETRY_LIMIT
) (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic enabled,
  input  wire logic unlimited,
  input  wire logic attempt,
  input  wire logic clear,
  output wire logic grant,
  output wire logic full,
  output wire logic [$clog2(LIMIT+1)-1:0] count
);

  localparam int CNT_W = $clog2(LIMIT + 1);
  localparam logic [CNT_W-1:0] LIMIT_C = CNT_W'(LIMIT);

  initial begin
    if (LIMIT < 1) begin
      $error("retry limit must be at least one");
    end
  end

  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic             full;
  } cnt_state_t;

  cnt_state_t state_reg;
  cnt_state_t state_next;

  assign grant = attempt && enabled && (unlimited || state_reg.count != LIMIT_C);
  assign full  = state_reg.full;
  assign count = state_reg.count;

  always_comb begin
    state_next = state_reg;
    // Only an explicit clear empties it; fault removal and delatch do not
    if (clear) begin
      state_next.count = '0;
    end
    // A retry in the clearing cycle still counts
    if (grant && state_next.count != LIMIT_C) begin
      state_next.count = state_next.count + CNT_W'(1);
    end
    state_next.full = (state_next.count == LIMIT_C);
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence limit_reached_s;
    state_reg.count == LIMIT_C && !unlimited;
  endsequence

  limit_stop_a: assert property (limit_reached_s |-> !grant)
    else $error("retry granted past the limit");
  unlimited_a: assert property (attempt && enabled && unlimited |-> grant)
    else $error("unlimited retry refused");
  no_clear_a: assert property (!$past(clear) |-> state_reg.count >= $past(state_reg.count))
    else $error("retry count fell without a clear");

endmodule : retry_limit_counter

/* File: rtl/overcurrent_retry_config.sv */
// Two-channel over-current profile and auto-retry configuration bank
`timescale 1ns/1ps
// What this block does
// - High range clear forces highest low level
// - High range set: low bit picks middle/lowest
// - No current sensing during protection windows
// - Prescale bit divides external clock 512/256
// - Clock bit selects internal or external clock
// - Ratio bit selects low or high sense ratio
// - Low ratio scales thresholds to one third
// - Bulb three thresholds, motor two thresholds
// - High, middle two values; low three
// - Bulb: two windows chosen by bits
// - Motor: one window from two bits
// - Upper select picks higher or lower value
// - Middle select ignored in motor mode
// - Offset polarity adds or subtracts sense offset
// - Two bits pick one of four periods
// - Unlimited bit allows endless enabled retries
// - Otherwise stop after sixteen retries
// - Counter survives delatch and fault removal
// - Bulb strap: control bit one disables retry
// - Motor strap: control bit one enables retry
// - Strap zero bulb, one motor
module overcurrent_retry_config #(
  parameter int CHANNELS    = 2,
  parameter int RETRY_LIMIT = ocr_pkg::RETRY_LIMIT
) (
  input  wire logic                       clock,
  input  wire logic                       rst,
  input  wire ocr_pkg::cmd_t              cmd,
  input  wire logic                       rd_bank,
  input  wire logic [2:0]                 rd_addr,
  output wire logic [8:0]                 rd_data,
  input  wire logic [CHANNELS-1:0]        load_type_strap,
  input  wire logic [CHANNELS-1:0]        window_active,
  input  wire logic [CHANNELS-1:0]        sense_request,
  output wire logic [CHANNELS-1:0]        sense_enable,
  input  wire logic [CHANNELS-1:0]        retry_attempt,
  input  wire logic [CHANNELS-1:0]        retry_counter_clear,
  output wire logic [CHANNELS-1:0]        retry_grant,
  output wire logic [CHANNELS-1:0]        retry_full,
  output ocr_pkg::ch_cfg_t [CHANNELS-1:0] cfg
);

  initial begin
    if (CHANNELS < 1 || CHANNELS > 2) begin
      $error("one bank bit serves one or two channels only");
    end
    if (RETRY_LIMIT < 1) begin
      $error("retry limit must be at least one");
    end
  end

  typedef struct packed {
    ocr_pkg::phase_t                     phase;
    logic [CHANNELS-1:0]                 motor;
    logic [CHANNELS-1:0][8:0]            ocr;
    logic [CHANNELS-1:0][8:0]            retry;
    ocr_pkg::ch_cfg_t [CHANNELS-1:0]     cfg;
    logic [8:0]                          rd_data;
  } main_state_t;

  main_state_t                     state_reg;
  main_state_t                     state_next;
  ocr_pkg::ch_cfg_t [CHANNELS-1:0] cfg_decoded;
  logic                            wr_bank;
  logic [2:0]                      wr_addr;
  logic [8:0]                      wr_data;
  logic                            running;

  assign wr_bank = cmd.word[ocr_pkg::BANK_BIT];
  assign wr_addr = cmd.word[ocr_pkg::ADDR_HI:ocr_pkg::ADDR_LO];
  assign wr_data = cmd.word[ocr_pkg::DATA_W-1:0];
  assign running = (state_reg.phase == ocr_pkg::ST_RUN);

  assign rd_data = state_reg.rd_data;
  assign cfg     = state_reg.cfg;

  // Sensing is gated straight from the window so no cycle leaks through
  assign sense_enable = sense_request & ~window_active & {CHANNELS{running}};

  always_comb begin
    state_next = state_reg;
    unique case (state_reg.phase)
      ocr_pkg::ST_CAPTURE: begin
        // Strap is sampled once, on the first edge after reset release
        state_next.motor = load_type_strap;
        state_next.phase = ocr_pkg::ST_RUN;
      end
      ocr_pkg::ST_RUN: begin
        state_next.phase = ocr_pkg::ST_RUN;
      end
      default: begin
        state_next.phase = ocr_pkg::ST_CAPTURE;
      end
    endcase

    for (int i = 0; i < CHANNELS; i++) begin
      if (cmd.valid && int'(wr_bank) == i) begin
        if (wr_addr == ocr_pkg::ADDR_OCR) begin
          state_next.ocr[i] = wr_data;
        end
        if (wr_addr == ocr_pkg::ADDR_RETRY) begin
          state_next.retry[i] = wr_data;
        end
      end
    end

    // Settings trail the register by one edge so they always come from flops
    state_next.cfg = cfg_decoded;

    state_next.rd_data = ocr_pkg::READ_UNMAPPED;
    if (int'(rd_bank) < CHANNELS) begin
      if (rd_addr == ocr_pkg::ADDR_OCR) begin
        state_next.rd_data = state_reg.ocr[rd_bank];
      end else if (rd_addr == ocr_pkg::ADDR_RETRY) begin
        state_next.rd_data = state_reg.retry[rd_bank];
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg       <= '0;
      state_reg.phase <= ocr_pkg::ST_CAPTURE;
    end else begin
      state_reg <= state_next;
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++) begin : g_chan

      ocr_field_decode u_decode (
        .ocr   (state_reg.ocr[ch]),
        .retry (state_reg.retry[ch]),
        .motor (state_reg.motor[ch]),
        .cfg   (cfg_decoded[ch])
      );

      // Counter works from the registered settings, one edge behind writes
      retry_limit_counter #(
        .LIMIT (RETRY_LIMIT)
      ) u_retry (
        .clock     (clock),
        .rst       (rst),
        .enabled   (state_reg.cfg[ch].retry_enabled),
        .unlimited (state_reg.cfg[ch].retry_unlimited),
        .attempt   (retry_attempt[ch] && running),
        .clear     (retry_counter_clear[ch]),
        .grant     (retry_grant[ch]),
        .full      (retry_full[ch]),
        .count     ()
      );

      // Checks on settled settings only; first cycles use a stale strap
      sequence settled_s;
        $past(state_reg.phase) == ocr_pkg::ST_RUN;
      endsequence

      sequence ch_write_s(logic [2:0] addr);
        $past(cmd.valid) && $past(wr_bank) == 1'(ch) && $past(wr_addr) == addr;
      endsequence

      low_range_a: assert property (@(posedge clock) disable iff (rst)
        settled_s and !$past(state_reg.ocr[ch][ocr_pkg::OCR_HIGH_RANGE])
        |-> state_reg.cfg[ch].low_level == ocr_pkg::LOW_L1)
        else $error("low level not highest with high range clear");

      low_select_a: assert property (@(posedge clock) disable iff (rst)
        settled_s and $past(state_reg.ocr[ch][ocr_pkg::OCR_HIGH_RANGE])
        |-> state_reg.cfg[ch].low_level == ($past(state_reg.ocr[ch][ocr_pkg::OCR_LOW])
                                            ? ocr_pkg::LOW_L3 : ocr_pkg::LOW_L2))
        else $error("low level select wrong with high range set");

      sense_block_a: assert property (@(posedge clock) disable iff (rst)
        window_active[ch] |-> !sense_enable[ch])
        else $error("sensing enabled inside protection window");

      prescale_div_a: assert property (@(posedge clock) disable iff (rst)
        settled_s |-> state_reg.cfg[ch].pwm_divider ==
          ($past(state_reg.ocr[ch][ocr_pkg::OCR_PRESCALE]) ? 10'h200 : 10'h100))
        else $error("pwm divider does not follow prescale bit");

      clock_source_a: assert property (@(posedge clock) disable iff (rst)
        settled_s |-> state_reg.cfg[ch].internal_clock ==
          $past(state_reg.ocr[ch][ocr_pkg::OCR_CLOCK_INT]))
        else $error("clock source does not follow its bit");

      ratio_scale_a: assert property (@(posedge clock) disable iff (rst)
        settled_s |-> state_reg.cfg[ch].low_ratio == $past(state_reg.ocr[ch][ocr_pkg::OCR_RATIO])
                      && state_reg.cfg[ch].scale_third == state_reg.cfg[ch].low_ratio)
        else $error("sense ratio and threshold scaling disagree");

      bulb_windows_a: assert property (@(posedge clock) disable iff (rst)
        settled_s and !$past(state_reg.motor[ch])
        |-> state_reg.cfg[ch].second_window != ocr_pkg::WIN_NONE
            && state_reg.cfg[ch].threshold_count == 2'h3)
        else $error("bulb profile lacks its second window");

      motor_window_a: assert property (@(posedge clock) disable iff (rst)
        settled_s and $past(state_reg.motor[ch])
        |-> state_reg.cfg[ch].second_window == ocr_pkg::WIN_NONE
            && !state_reg.cfg[ch].middle_low
            && state_reg.cfg[ch].threshold_count == 2'h2)
        else $error("motor profile decode wrong");

      retry_sense_a: assert property (@(posedge clock) disable iff (rst)
        settled_s |-> state_reg.cfg[ch].retry_enabled ==
          ($past(state_reg.retry[ch][ocr_pkg::RTY_CTRL]) ^ !$past(state_reg.motor[ch])))
        else $error("retry enable sense wrong for strap");

      write_take_a: assert property (@(posedge clock) disable iff (rst)
        ch_write_s(ocr_pkg::ADDR_OCR) |-> state_reg.ocr[ch] == $past(wr_data))
        else $error("write to this bank not stored");

      write_hold_a: assert property (@(posedge clock) disable iff (rst)
        !ch_write_s(ocr_pkg::ADDR_RETRY) |-> $stable(state_reg.retry[ch]))
        else $error("retry register changed without a write");

    end
  endgenerate

endmodule : overcurrent_retry_config

/* File: testbench/ocr_host_model.sv */
// Serial host model: writes decoded words and selects registers for read-back
`timescale 1ns/1ps
module ocr_host_model (
  input  wire logic    clock,
  output ocr_pkg::cmd_t cmd,
  output logic         rd_bank,
  output logic [2:0]   rd_addr
);
  initial begin
    cmd     = '0;
    rd_bank = 1'b0;
    rd_addr = 3'h0;
  end

  // Called at a falling edge; the word is taken at the rising edge between
  task automatic wr(input logic bank, input logic [2:0] addr, input logic [8:0] data);
    cmd.valid = 1'b1;
    cmd.word  = {2'b00, bank, addr, 1'b0, data};
    @(negedge clock);
    cmd.valid = 1'b0;
    // Idle word scrambled so nothing can lean on a stale value
    cmd.word  = ~cmd.word;
    // Idle cycle so a following call never re-raises valid in this step
    @(negedge clock);
  endtask : wr

  task automatic rd(input logic bank, input logic [2:0] addr);
    rd_bank = bank;
    rd_addr = addr;
    @(negedge clock);
  endtask : rd
endmodule : ocr_host_model

/* File: testbench/tb_top.sv */
// Self-checking bench for the over-current and auto-retry configuration bank
`timescale 1ns/1ps
`define CMP(nm, e, o) begin cmp_count++; if ((o) !== (e)) begin \
  $display("[ERR] %s exp %0h got %0h", nm, e, o); err_total++; end end
module tb_top;
  typedef struct packed {
    logic [1:0]       kind;
    logic             ch;
    ocr_pkg::ch_cfg_t cfg;
    logic [8:0]       d;
  } note_t;

  logic                   clock = 1'b0;
  logic                   rst = 1'b1;
  ocr_pkg::cmd_t          cmd;
  logic                   rd_bank;
  logic [2:0]             rd_addr;
  logic [8:0]             rd_data;
  logic [1:0]             strap = 2'b00;
  logic [1:0]             win = 2'b00;
  logic [1:0]             req = 2'b00;
  logic [1:0]             sense_enable;
  logic [1:0]             attempt = 2'b00;
  logic [1:0]             clr = 2'b00;
  logic [1:0]             retry_grant;
  logic [1:0]             retry_full;
  ocr_pkg::ch_cfg_t [1:0] cfg;
  logic                   note_go = 1'b0;
  note_t                  exp_q[$];
  int                     err_total = 0;
  int                     cmp_count = 0;
  integer                 seed = 39802;

  always #2 clock = ~clock;

  ocr_host_model host_u (.clock(clock), .cmd(cmd), .rd_bank(rd_bank), .rd_addr(rd_addr));

  overcurrent_retry_config dut_u (
    .clock(clock), .rst(rst), .cmd(cmd), .rd_bank(rd_bank), .rd_addr(rd_addr),
    .rd_data(rd_data), .load_type_strap(strap), .window_active(win),
    .sense_request(req), .sense_enable(sense_enable), .retry_attempt(attempt),
    .retry_counter_clear(clr), .retry_grant(retry_grant), .retry_full(retry_full),
    .cfg(cfg));

  function automatic ocr_pkg::ch_cfg_t exp_cfg(input logic [8:0] o, input logic [8:0] r,
                                               input logic m);
    ocr_pkg::ch_cfg_t e;
    e = '0;
    e.low_level = !o[8] ? ocr_pkg::LOW_L1 : (o[0] ? ocr_pkg::LOW_L3 : ocr_pkg::LOW_L2);
    e.upper_low = o[2];
    e.middle_low = o[1];
    e.middle_used = !m;
    e.threshold_count = m ? 2'h2 : 2'h3;
    e.scale_third = o[5];
    e.low_ratio = o[5];
    e.pwm_divider = o[7] ? 10'h200 : 10'h100;
    e.internal_clock = o[6];
    e.offset_add = r[8];
    e.retry_period = r[3:2];
    e.retry_enabled = m ? r[0] : !r[0];
    e.retry_unlimited = r[1];
    if (m) begin
      e.first_window = o[4] ? (o[3] ? ocr_pkg::WIN_HIGH2 : ocr_pkg::WIN_HIGH1)
                            : (o[3] ? ocr_pkg::WIN_MID2_MOTOR : ocr_pkg::WIN_MID1_MOTOR);
      e.second_window = ocr_pkg::WIN_NONE;
    end else begin
      e.first_window = o[4] ? ocr_pkg::WIN_HIGH2 : ocr_pkg::WIN_HIGH1;
      e.second_window = o[3] ? ocr_pkg::WIN_MID2_BULB : ocr_pkg::WIN_MID1_BULB;
    end
    return e;
  endfunction : exp_cfg

  // Sampled at the next rising edge, so inputs must hold until then
  task automatic note(input logic [1:0] k, input logic ch, input ocr_pkg::ch_cfg_t c,
                      input logic [8:0] d);
    exp_q.push_back('{kind: k, ch: ch, cfg: c, d: d});
    note_go = 1'b1;
    @(negedge clock);
    note_go = 1'b0;
  endtask : note

  always @(posedge clock) begin
    note_t            n;
    ocr_pkg::ch_cfg_t c;
    if (note_go) begin
      n = exp_q.pop_front();
      c = cfg[n.ch];
      if (n.kind == 2'd0) begin
        `CMP("low_level", n.cfg.low_level, c.low_level)
        `CMP("upper_low", n.cfg.upper_low, c.upper_low)
        if (n.cfg.middle_used) `CMP("middle_low", n.cfg.middle_low, c.middle_low)
        `CMP("middle_used", n.cfg.middle_used, c.middle_used)
        `CMP("thr_count", n.cfg.threshold_count, c.threshold_count)
        `CMP("scale", n.cfg.scale_third, c.scale_third)
        `CMP("win1", n.cfg.first_window, c.first_window)
        `CMP("win2", n.cfg.second_window, c.second_window)
        `CMP("divider", n.cfg.pwm_divider, c.pwm_divider)
        `CMP("int_clk", n.cfg.internal_clock, c.internal_clock)
        `CMP("ratio", n.cfg.low_ratio, c.low_ratio)
        `CMP("offset", n.cfg.offset_add, c.offset_add)
        `CMP("period", n.cfg.retry_period, c.retry_period)
        `CMP("retry_en", n.cfg.retry_enabled, c.retry_enabled)
        `CMP("unlim", n.cfg.retry_unlimited, c.retry_unlimited)
      end else if (n.kind == 2'd1) begin
        `CMP("rd_data", n.d, rd_data)
      end else begin
        `CMP("grant", n.d[0], retry_grant[n.ch])
        `CMP("full", n.d[1], retry_full[n.ch])
        `CMP("sense", n.d[2], sense_enable[n.ch])
      end
    end
  end

  task automatic finish_test;
    if (err_total == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test

  task automatic do_reset(input logic [1:0] s);
    rst = 1'b1;
    strap = s;
    repeat (10) @(negedge clock);
    rst = 1'b0;
    repeat (2) @(negedge clock);
  endtask : do_reset

  // Retry-period, level and window bits walk every code; the rest is random
  task automatic run_phase(input logic [1:0] s);
    logic [8:0] o;
    logic [8:0] r;
    logic       ch;
    do_reset(s);
    for (int b = 0; b < 2; b++) begin
      note(2'd0, b[0], exp_cfg(9'h000, 9'h000, s[b]), 9'h000);
      host_u.rd(b[0], ocr_pkg::ADDR_OCR);
      note(2'd1, b[0], '0, 9'h000);
      host_u.rd(b[0], 3'h7);
      note(2'd1, b[0], '0, 9'h000);
    end
    for (int i = 0; i < 16; i++) begin
      ch = i[3];
      o = 9'($random(seed));
      r = 9'($random(seed));
      o[8] = i[1];
      o[4:3] = i[1:0];
      o[0] = i[0];
      r[3:2] = i[3:2];
      host_u.wr(ch, ocr_pkg::ADDR_OCR, o);
      host_u.wr(ch, ocr_pkg::ADDR_RETRY, r);
      host_u.wr(ch, 3'h6, ~o);
      repeat (2) @(negedge clock);
      note(2'd0, ch, exp_cfg(o, r, s[ch]), 9'h000);
      host_u.rd(ch, ocr_pkg::ADDR_OCR);
      note(2'd1, ch, '0, o);
      host_u.rd(ch, ocr_pkg::ADDR_RETRY);
      note(2'd1, ch, '0, r);
    end
    for (int k = 0; k < 8; k++) begin
      win = 2'($random(seed));
      req = 2'($random(seed));
      note(2'd2, 1'b0, '0, {6'h00, req[0] & ~win[0], 2'b00});
      note(2'd2, 1'b1, '0, {6'h00, req[1] & ~win[1], 2'b00});
    end
    req = 2'b00;
  endtask : run_phase

  task automatic set_retry(input logic ch, input logic [8:0] r);
    host_u.wr(ch, ocr_pkg::ADDR_RETRY, r);
    repeat (3) @(negedge clock);
  endtask : set_retry

  initial begin
    #(4 * 20000);
    err_total++;
    finish_test();
  end

  initial begin
    @(negedge clock);
    run_phase(2'b10);
    // Channel 1 is a motor here: limited retries run out after sixteen
    set_retry(1'b1, 9'h001);
    clr[1] = 1'b1;
    @(negedge clock);
    clr[1] = 1'b0;
    attempt[1] = 1'b1;
    for (int k = 0; k < 16; k++) note(2'd2, 1'b1, '0, 9'h001);
    note(2'd2, 1'b1, '0, 9'h002);
    attempt[1] = 1'b0;
    repeat (5) @(negedge clock);
    note(2'd2, 1'b1, '0, 9'h002);
    set_retry(1'b1, 9'h003);
    attempt[1] = 1'b1;
    note(2'd2, 1'b1, '0, 9'h003);
    attempt[1] = 1'b0;
    set_retry(1'b1, 9'h000);
    attempt[1] = 1'b1;
    note(2'd2, 1'b1, '0, 9'h002);
    attempt = 2'b00;
    // Channel 0 is a bulb: control bit clear enables, set disables
    set_retry(1'b0, 9'h000);
    attempt[0] = 1'b1;
    note(2'd2, 1'b0, '0, 9'h001);
    attempt[0] = 1'b0;
    set_retry(1'b0, 9'h001);
    attempt[0] = 1'b1;
    note(2'd2, 1'b0, '0, 9'h000);
    attempt = 2'b00;
    run_phase(2'b01);
    repeat (3) @(negedge clock);
    finish_test();
  end
endmodule : tb_top
